/* File: s2mst_pkg.sv */
// package for the write-channel status block: offsets, fields, states, carriers
`default_nettype none
package s2mst_pkg;
  // register byte offsets on the apb slave
  localparam logic [7:0] OFF_CTRL   = 8'h30;
  localparam logic [7:0] OFF_STATUS = 8'h34;
  localparam logic [7:0] OFF_TAIL   = 8'h40;
  localparam logic [7:0] OFF_LENGTH = 8'h58;
  localparam logic [7:0] OFF_IRQ_ST = 8'h60;
  localparam logic [7:0] OFF_IRQ_MK = 8'h64;
  // status field positions
  localparam int BIT_HALTED  = 0;
  localparam int BIT_IDLE    = 1;
  localparam int BIT_RSVD    = 2;
  localparam int BIT_SG_INCL = 3;
  localparam int BIT_INT_ERR = 4;
  // control field position
  localparam int BIT_RUN     = 0;
  // interrupt status positions
  localparam int IRQ_IDLE    = 0;
  localparam int IRQ_ERR     = 1;
  localparam int IRQ_HALT    = 2;
  localparam int IRQ_W       = 3;
  // reset values
  localparam logic [31:0] RST_CTRL   = 32'h0000_0000;
  localparam logic [31:0] RST_LENGTH = 32'h0000_0000;
  localparam logic [IRQ_W-1:0] RST_MASK = 3'h0;
  // cycles for the engine to drain after run is cleared
  localparam int DRAIN_CYC  = 4;

  typedef enum {ST_HALTED, ST_ACTIVE, ST_IDLE, ST_DRAIN} s2mst_state_e;

  // stream beat from the packet source
  typedef struct packed {
    logic        valid;
    logic        last;
    logic [15:0] bytes;
  } s2mst_beat_s;

  // events reported by the surrounding engine
  typedef struct packed {
    logic        desc_fetch;
    logic [31:0] desc_len;
    logic        sts_valid;
    logic [31:0] rx_len;
    logic        mem_err;
    logic        xfer_done;
    logic        ring_done;
    logic        busy;
  } s2mst_eng_s;
endpackage : s2mst_pkg
`default_nettype wire

/* File: s2mst_drain.sv */
// drain timer: counts down quiet cycles before the channel may report halted
`default_nettype none
module s2mst_drain #(
  parameter int CYC = s2mst_pkg::DRAIN_CYC
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic start,
  input  wire logic busy,
  output var  logic done
);
  logic [7:0] cnt_q;
  logic       run_q;

  // restart whenever the engine is still busy, so halt waits for true quiet
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 8'h00;
      run_q <= 1'b0;
    end else if (start || (run_q && busy)) begin
      cnt_q <= 8'(CYC);
      run_q <= 1'b1;
    end else if (run_q && cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end else begin
      run_q <= 1'b0;
    end
  end

  assign done = run_q && (cnt_q == 8'h00) && !busy;
endmodule : s2mst_drain
`default_nettype wire

/* File: s2mst_core.sv */
// status logic of the stream-to-memory write channel with apb registers
//
// The placing of the registers and the APB register port were decided locally.
`default_nettype none
module s2mst_core #(
  parameter bit SG_INCLUDE = 1'b1,
  parameter bit STS_LEN_EN = 1'b1
) (
  input  wire logic                  SYS_CLK,
  input  wire logic                  RST,
  input  wire logic                  PSEL,
  input  wire logic                  PENABLE,
  input  wire logic                  PWRITE,
  input  wire logic [7:0]            PADDR,
  input  wire logic [31:0]           PWDATA,
  output var  logic [31:0]           PRDATA,
  output var  logic                  PREADY,
  output var  logic                  PSLVERR,
  input  wire s2mst_pkg::s2mst_beat_s BEAT,
  input  wire s2mst_pkg::s2mst_eng_s  ENG,
  output var  logic                  RUN_STOP,
  output var  logic                  TAIL_WRITE,
  output var  logic [31:0]           LENGTH,
  output var  logic                  IRQ
);
  logic        apb_wr;
  logic        apb_rd;
  logic        hit;
  logic        wr_ctrl;
  logic        wr_tail;
  logic        wr_len;
  logic        wr_ist;
  logic        wr_msk;
  logic        run_q;
  logic        halted_q;
  logic        idle_q;
  logic        err_q;
  logic        first_q;
  logic        tail_q;
  logic [31:0] len_q;
  logic [31:0] pkt_q;
  logic [31:0] pkt_sum;
  logic        err_ev;
  logic        drain_done;
  logic        drain_start;
  logic        halt_ev;
  logic [s2mst_pkg::IRQ_W-1:0] ist_q;
  logic [s2mst_pkg::IRQ_W-1:0] msk_q;
  logic [s2mst_pkg::IRQ_W-1:0] ev;
  logic [31:0] status;
  s2mst_pkg::s2mst_state_e st_q;

  // apb access strobes; the slave answers with zero wait states
  assign apb_wr  = PSEL && PENABLE && PWRITE;
  assign apb_rd  = PSEL && !PWRITE;
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !hit;

  // address decode; anything off the map answers with a slave error
  always_comb begin
    case (PADDR)
      s2mst_pkg::OFF_CTRL,
      s2mst_pkg::OFF_STATUS,
      s2mst_pkg::OFF_TAIL,
      s2mst_pkg::OFF_LENGTH,
      s2mst_pkg::OFF_IRQ_ST,
      s2mst_pkg::OFF_IRQ_MK: hit = 1'b1;
      default:               hit = 1'b0;
    endcase
  end

  // write strobes per register, taken in the access phase only
  assign wr_ctrl = apb_wr && (PADDR == s2mst_pkg::OFF_CTRL);
  assign wr_tail = apb_wr && (PADDR == s2mst_pkg::OFF_TAIL);
  assign wr_len  = apb_wr && (PADDR == s2mst_pkg::OFF_LENGTH);
  assign wr_ist  = apb_wr && (PADDR == s2mst_pkg::OFF_IRQ_ST);
  assign wr_msk  = apb_wr && (PADDR == s2mst_pkg::OFF_IRQ_MK);

  // running byte count of the current packet including this beat
  assign pkt_sum = pkt_q + {16'h0000, BEAT.bytes};

  // error sources, gated by build mode
  always_comb begin
    err_ev = 1'b0;
    if (SG_INCLUDE && ENG.desc_fetch && ENG.desc_len == 32'h0000_0000) begin
      err_ev = 1'b1;
    end
    if (SG_INCLUDE && STS_LEN_EN && ENG.sts_valid && ENG.rx_len != pkt_q) begin
      err_ev = 1'b1;
    end
    if (!SG_INCLUDE && ENG.mem_err) begin
      err_ev = 1'b1;
    end
    if (!SG_INCLUDE && BEAT.valid && pkt_sum > len_q) begin
      err_ev = 1'b1;
    end
  end

  // packet byte counter; held after last so the status stream can compare
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      pkt_q <= 32'h0000_0000;
    end else if (ENG.sts_valid) begin
      pkt_q <= 32'h0000_0000;
    end else if (!SG_INCLUDE && BEAT.valid && BEAT.last) begin
      // no status stream in direct mode, so each packet restarts the count
      pkt_q <= 32'h0000_0000;
    end else if (BEAT.valid) begin
      pkt_q <= pkt_sum;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      err_q <= 1'b0;
    end else if (err_ev) begin
      err_q <= 1'b1;
    end
  end

  // run/stop: software sets it, an error forces it low and wins over the write
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      run_q <= s2mst_pkg::RST_CTRL[s2mst_pkg::BIT_RUN];
    end else if (err_ev || err_q) begin
      run_q <= 1'b0;
    end else if (wr_ctrl) begin
      run_q <= PWDATA[s2mst_pkg::BIT_RUN];
    end
  end

  // tail write pulse, one cycle after the access; dropped while halted
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      tail_q <= 1'b0;
    end else begin
      tail_q <= wr_tail && !halted_q && SG_INCLUDE;
    end
  end

  // length register; a halted channel ignores new lengths
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      len_q <= s2mst_pkg::RST_LENGTH;
    end else if (wr_len && !halted_q) begin
      len_q <= PWDATA;
    end
  end

  // drain starts the cycle run drops while active or idle
  assign drain_start = !run_q && !halted_q && (st_q != s2mst_pkg::ST_DRAIN);

  // quiet-cycle timer that gates the halted report
  s2mst_drain #(
    .CYC (s2mst_pkg::DRAIN_CYC)
  ) u_drain (
    .clk   (SYS_CLK),
    .rst   (RST),
    .start (drain_start),
    .busy  (ENG.busy),
    .done  (drain_done)
  );

  // channel state: halted, active, idle, draining
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      st_q     <= s2mst_pkg::ST_HALTED;
      halted_q <= 1'b1;
      idle_q   <= 1'b0;
      first_q  <= 1'b0;
    end else begin
      case (st_q)
        s2mst_pkg::ST_HALTED: begin
          if (run_q) begin
            st_q     <= s2mst_pkg::ST_ACTIVE;
            halted_q <= 1'b0;
          end
        end
        s2mst_pkg::ST_ACTIVE: begin
          if (!run_q) begin
            st_q   <= s2mst_pkg::ST_DRAIN;
            idle_q <= 1'b0;
          end else if (SG_INCLUDE && ENG.ring_done) begin
            st_q   <= s2mst_pkg::ST_IDLE;
            idle_q <= 1'b1;
          end else if (!SG_INCLUDE && ENG.xfer_done) begin
            st_q    <= s2mst_pkg::ST_IDLE;
            idle_q  <= 1'b1;
            first_q <= 1'b1;
          end
        end
        s2mst_pkg::ST_IDLE: begin
          if (!run_q) begin
            st_q   <= s2mst_pkg::ST_DRAIN;
            idle_q <= 1'b0;
          end else if (tail_q || (!SG_INCLUDE && wr_len)) begin
            st_q   <= s2mst_pkg::ST_ACTIVE;
            idle_q <= 1'b0;
          end
        end
        s2mst_pkg::ST_DRAIN: begin
          if (drain_done) begin
            st_q     <= s2mst_pkg::ST_HALTED;
            halted_q <= 1'b1;
          end
        end
        default: begin
          st_q <= s2mst_pkg::ST_HALTED;
        end
      endcase
    end
  end

  // status word assembly
  always_comb begin
    status = 32'h0000_0000;
    status[s2mst_pkg::BIT_HALTED]  = halted_q;
    // idle masked by halt, and in direct mode until the first transfer is done
    status[s2mst_pkg::BIT_IDLE]    = idle_q && !halted_q && (SG_INCLUDE || first_q);
    status[s2mst_pkg::BIT_RSVD]    = 1'b0;
    status[s2mst_pkg::BIT_SG_INCL] = SG_INCLUDE;
    status[s2mst_pkg::BIT_INT_ERR] = err_q;
  end

  // interrupt events: idle entry, error, halt entry
  assign halt_ev = (st_q == s2mst_pkg::ST_DRAIN) && drain_done;
  always_comb begin
    ev = '0;
    ev[s2mst_pkg::IRQ_IDLE] = (st_q == s2mst_pkg::ST_ACTIVE) && run_q &&
                              ((SG_INCLUDE && ENG.ring_done) || (!SG_INCLUDE && ENG.xfer_done));
    ev[s2mst_pkg::IRQ_ERR]  = err_ev && !err_q;
    ev[s2mst_pkg::IRQ_HALT] = halt_ev;
  end

  // sticky interrupt status; a new event wins over a write-one clear
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ist_q <= '0;
    end else if (wr_ist) begin
      ist_q <= (ist_q & ~PWDATA[s2mst_pkg::IRQ_W-1:0]) | ev;
    end else begin
      ist_q <= ist_q | ev;
    end
  end

  // interrupt mask, plain read/write
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      msk_q <= s2mst_pkg::RST_MASK;
    end else if (wr_msk) begin
      msk_q <= PWDATA[s2mst_pkg::IRQ_W-1:0];
    end
  end

  // read data registered at setup so it is stable in the access phase
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      PRDATA <= 32'h0000_0000;
    end else if (apb_rd && !PENABLE) begin
      case (PADDR)
        s2mst_pkg::OFF_CTRL:   PRDATA <= {31'h0000_0000, run_q};
        s2mst_pkg::OFF_STATUS: PRDATA <= status;
        s2mst_pkg::OFF_LENGTH: PRDATA <= len_q;
        s2mst_pkg::OFF_IRQ_ST: PRDATA <= {29'h0000_0000, ist_q};
        s2mst_pkg::OFF_IRQ_MK: PRDATA <= {29'h0000_0000, msk_q};
        default:               PRDATA <= 32'h0000_0000;
      endcase
    end
  end

  // outputs straight from the registers; irq is the or of the status bits enabled by the mask
  assign RUN_STOP   = run_q;
  assign TAIL_WRITE = tail_q;
  assign LENGTH     = len_q;
  assign IRQ        = |(ist_q & msk_q);
endmodule : s2mst_core
`default_nettype wire

/* File: s2mst_sva.sv */
// checker of status and control behaviour at the core ports
`default_nettype none
module s2mst_sva #(
  parameter bit SG_INCLUDE = 1'b1
) (
  input wire logic                  SYS_CLK,
  input wire logic                  RST,
  input wire logic                  PSEL,
  input wire logic                  PENABLE,
  input wire logic                  PWRITE,
  input wire logic [7:0]            PADDR,
  input wire logic [31:0]           PRDATA,
  input wire s2mst_pkg::s2mst_eng_s ENG,
  input wire logic                  RUN_STOP,
  input wire logic                  TAIL_WRITE
);
  logic rd_st;
  logic wr_tl;
  // access phases of a status read and a tail write
  assign rd_st = PSEL && PENABLE && !PWRITE && PADDR == s2mst_pkg::OFF_STATUS;
  assign wr_tl = PSEL && PENABLE && PWRITE && PADDR == s2mst_pkg::OFF_TAIL;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  property p_rsvd; rd_st |-> !PRDATA[2]; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit read high");
  property p_sgin; rd_st |-> PRDATA[3] == SG_INCLUDE; endproperty
  a_sgin: assert property (p_sgin) else $error("build bit wrong");
  property p_idle; rd_st && PRDATA[0] |-> !PRDATA[1]; endproperty
  a_idle: assert property (p_idle) else $error("idle while halted");
  property p_halt; rd_st && PRDATA[0] |-> !$past(RUN_STOP, 2); endproperty
  a_halt: assert property (p_halt) else $error("halted with run set");
  // halted must lag the run clear by the drain
  property p_drn; rd_st && PRDATA[0] |-> !$past(RUN_STOP, 5); endproperty
  a_drn: assert property (p_drn) else $error("halted before drain");
  property p_zlen; SG_INCLUDE && ENG.desc_fetch && ENG.desc_len == 32'h0 |-> ##[1:2] !RUN_STOP;
  endproperty
  a_zlen: assert property (p_zlen) else $error("run kept after zero length");
  property p_tgo; wr_tl && RUN_STOP && $past(RUN_STOP) |=> TAIL_WRITE; endproperty
  a_tgo: assert property (p_tgo) else $error("tail write not passed on");
  property p_tsrc; TAIL_WRITE |-> $past(wr_tl); endproperty
  a_tsrc: assert property (p_tsrc) else $error("tail pulse without write");
  property p_tone; TAIL_WRITE |=> !TAIL_WRITE; endproperty
  a_tone: assert property (p_tone) else $error("tail pulse too long");
endmodule : s2mst_sva
bind s2mst_core s2mst_sva #(.SG_INCLUDE(SG_INCLUDE)) s2mst_sva_i (.SYS_CLK(SYS_CLK),
  .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PRDATA(PRDATA), .ENG(ENG), .RUN_STOP(RUN_STOP), .TAIL_WRITE(TAIL_WRITE));
`default_nettype wire

/* File: s2mst_src.sv */
// stream source and engine event model facing the core
`default_nettype none
module s2mst_src (
  input  wire logic                   clk,
  output var  s2mst_pkg::s2mst_beat_s beat,
  output var  s2mst_pkg::s2mst_eng_s  eng
);
  timeunit 1ns;
  timeprecision 1ps;
  // quiet lines at time zero
  initial begin
    beat = '0;
    eng = '0;
  end
  // one pulse; data fields flip once released so stale values never match
  task automatic ev(input int k, input logic [31:0] v);
    s2mst_pkg::s2mst_eng_s e;
    e = '0;
    e.desc_fetch = k == 0;
    e.desc_len = v;
    e.sts_valid = k == 1;
    e.rx_len = v;
    e.ring_done = k == 2;
    @(posedge clk);
    eng <= e;
    @(posedge clk);
    eng <= '{desc_len: ~v, rx_len: ~v, default: '0};
  endtask : ev
  // n beats of b bytes, busy held over the packet
  task automatic pkt(input int n, input logic [15:0] b);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      beat <= '{valid: 1'b1, last: i == n - 1, bytes: b};
      eng.busy <= 1'b1;
    end
    @(posedge clk);
    beat <= '{valid: 1'b0, last: 1'b0, bytes: ~b};
    eng.busy <= 1'b0;
  endtask : pkt
endmodule : s2mst_src
`default_nettype wire

/* File: tb.sv */
// self-checking bench for the write-channel status core
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   sys_clk, rst, psel, penable, pwrite;
  logic                   pready, pslverr, last_err, run_stop, tail_write, irq;
  logic [7:0]             paddr;
  logic [31:0]            pwdata, prdata, rdv, length;
  s2mst_pkg::s2mst_beat_s beat;
  s2mst_pkg::s2mst_eng_s  eng;
  int                     checked = 0;
  int                     miscompares = 0;
  int                     cycles = 0;
  s2mst_core s2mst_core_i (.SYS_CLK(sys_clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .BEAT(beat), .ENG(eng), .RUN_STOP(run_stop),
    .TAIL_WRITE(tail_write), .LENGTH(length), .IRQ(irq));
  s2mst_src s2mst_src_i (.clk(sys_clk), .beat(beat), .eng(eng));
  // 25 mhz clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic give_verdict;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict
  // hang guard, far above the roughly 150 cycles needed
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      give_verdict();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      $display("unexpected %s expected %h seen %h", n, e, s);
      miscompares++;
    end
  endtask : chk
  // apb transfer; data taken at the edge that sees pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rdv = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd_status(input logic [31:0] e);
    apb(1'b0, s2mst_pkg::OFF_STATUS, 32'h0);
    chk("status", e, rdv);
  endtask : rd_status
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic t_reset;
    rd_status(32'h09);
    apb(1'b0, 8'h00, 32'h0);
    chk("unmapped", 32'h1, {rdv[30:0], last_err});
    chk("run", 32'h0, {31'h0, run_stop});
  endtask : t_reset
  task automatic t_idle;
    apb(1'b1, s2mst_pkg::OFF_CTRL, 32'h1);
    s2mst_src_i.ev(0, 32'h8);
    s2mst_src_i.pkt(2, 16'h4);
    s2mst_src_i.ev(1, 32'h8);
    s2mst_src_i.ev(2, 32'h0);
    rd_status(32'h0a);
    apb(1'b1, s2mst_pkg::OFF_IRQ_MK, 32'h1);
    tick(1);
    chk("irq on", 32'h1, {31'h0, irq});
    apb(1'b1, s2mst_pkg::OFF_IRQ_MK, 32'h0);
    tick(1);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, s2mst_pkg::OFF_IRQ_ST, 32'h7);
    apb(1'b1, s2mst_pkg::OFF_IRQ_MK, 32'h7);
    tick(1);
    chk("irq cleared", 32'h0, {31'h0, irq});
  endtask : t_idle
  task automatic t_tail;
    logic seen;
    seen = 1'b0;
    apb(1'b1, s2mst_pkg::OFF_TAIL, 32'h100);
    // the pulse stands in the cycle right after the write edge
    repeat (3) begin
      #1;
      seen = seen | tail_write;
      @(posedge sys_clk);
    end
    chk("tail pulse", 32'h1, {31'h0, seen});
    rd_status(32'h08);
    apb(1'b1, s2mst_pkg::OFF_STATUS, 32'hff);
    rd_status(32'h08);
    apb(1'b1, s2mst_pkg::OFF_LENGTH, 32'h40);
    tick(1);
    chk("length out", 32'h40, length);
    apb(1'b0, s2mst_pkg::OFF_LENGTH, 32'h0);
    chk("length read", 32'h40, rdv);
  endtask : t_tail
  task automatic t_len;
    s2mst_src_i.pkt(2, 16'h5);
    s2mst_src_i.ev(1, 32'hb);
    tick(2);
    chk("run after error", 32'h0, {31'h0, run_stop});
    rd_status(32'h18);
    tick(10);
    rd_status(32'h19);
    chk("irq error", 32'h1, {31'h0, irq});
    apb(1'b1, s2mst_pkg::OFF_LENGTH, 32'h99);
    apb(1'b0, s2mst_pkg::OFF_LENGTH, 32'h0);
    chk("length halted", 32'h40, rdv);
    apb(1'b1, s2mst_pkg::OFF_CTRL, 32'h1);
    tick(2);
    rd_status(32'h19);
  endtask : t_len
  task automatic t_zlen;
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    rd_status(32'h09);
    chk("length reset", 32'h0, length);
    apb(1'b1, s2mst_pkg::OFF_CTRL, 32'h1);
    s2mst_src_i.ev(0, 32'h0);
    tick(2);
    chk("run zero length", 32'h0, {31'h0, run_stop});
    tick(10);
    rd_status(32'h19);
  endtask : t_zlen
  // reset, then the scenarios in order
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_idle();
    t_tail();
    t_len();
    t_zlen();
    give_verdict();
  end
endmodule : tb
`default_nettype wire
